// file: hdl/aisc_top.sv
// Input type, channel, range and output-coding control with serial-clock edge counting.
`timescale 1ns/10ps
`default_nettype none
module aisc_top
  import aisc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_b_i,
  input  wire logic              input_type_select_i,
  input  wire logic              chan_addr_bit0_i,
  input  wire logic              chan_addr_bit1_i,
  input  wire logic              chan_addr_bit2_i,
  input  wire logic              range_i,
  input  wire logic [CODE_W-1:0] raw_code_i,
  input  wire logic              raw_valid_i,
  output aisc_cfg_t              cfg_o,
  output logic [2:0]             pos_sel_o,
  output logic [2:0]             neg_sel_o,
  output logic                   neg_is_ground_o,
  output logic                   pseudo_o,
  output logic                   twos_comp_o,
  output logic [1:0]             lsb_shift_o,
  output logic                   tracking_o,
  output logic                   acq_ready_o,
  output logic                   acq_restart_o,
  output logic                   conv_corrupt_o,
  output logic                   addr_invalid_o,
  output logic [CODE_W-1:0]      result_o,
  output logic                   result_valid_o
);

  function automatic aisc_mode_t mode_of(input logic single, input logic a0);
    if (single) begin
      return AISC_SGL;
    end
    return a0 ? AISC_PSEUDO : AISC_FULL;
  endfunction : mode_of

  // Link domain: count rising serial edges within a frame. Chip-select high clears the
  // count, so nothing here relies on serial edges outside a frame.
  logic       frame_rst_b;
  logic [3:0] edge_cnt;
  logic       trk_tgl;

  assign frame_rst_b = rst_b_i & ~cs_b_i;

  always_ff @(posedge sclk_i or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      edge_cnt <= EDGE_CNT_RST;
    end else if (edge_cnt != TRACK_EDGE) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  // The toggle survives the frame end so the event is not lost if the clock stops.
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trk_tgl <= 1'b0;
    end else if (!cs_b_i && edge_cnt == TRACK_EDGE - 4'h1) begin
      trk_tgl <= ~trk_tgl;
    end
  end

  // Reference domain: the select, type, address and range pins and the toggle pass two flops first.
  logic [6:0] pin_s;
  logic       s_cs_b;
  logic       s_cs_on;
  logic       s_type;
  logic [2:0] s_addr;
  logic       s_range;
  logic       s_trk;

  aisc_sync #(.W(7)) u_sync (
    .clk_i   (ref_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({trk_tgl, ~cs_b_i, input_type_select_i, chan_addr_bit2_i,
                chan_addr_bit1_i, chan_addr_bit0_i, range_i}),
    .q_o     (pin_s)
  );

  assign {s_trk, s_cs_on, s_type, s_addr, s_range} = pin_s;
  // The select lane is carried inverted so that its reset value means deselected.
  // This keeps a false chip-select fall from following reset.
  assign s_cs_b = ~s_cs_on;

  logic        cs_q;
  logic        trk_q;
  aisc_state_t state;
  aisc_state_t next_state;
  aisc_cfg_t   cfg;
  logic [7:0]  acq_cnt;
  aisc_mode_t  cur_mode;

  wire        cs_fall    = cs_q & ~s_cs_b;
  wire        trk_ev     = s_trk ^ trk_q;
  wire        holding    = (state == AISC_HOLD);
  wire        type_chg   = holding && (s_type != cfg.single);
  wire        mode_chg   = holding && !type_chg &&
                           (mode_of(s_type, s_addr[0]) != cur_mode);
  wire        acq_clr    = cs_fall | mode_chg | trk_ev;

  // Decode of the live levels, taken into the registers at the chip-select fall.
  wire aisc_mode_t live_mode = mode_of(s_type, s_addr[0]);
  wire [2:0]  pair_pos   = {s_addr[2:1], 1'b0};
  wire [2:0]  next_pos   = s_type ? s_addr : pair_pos;
  wire [2:0]  next_neg   = s_type ? SEL_RST : (pair_pos + 3'h1);
  wire        next_twos  = (live_mode == AISC_FULL) | s_range;
  wire [1:0]  next_lsb   = {1'b0, live_mode != AISC_SGL} + {1'b0, s_range};

  always_comb begin
    next_state = state;
    unique case (state)
      AISC_TRACK: begin
        if (cs_fall) begin
          next_state = AISC_HOLD;
        end
      end
      AISC_HOLD: begin
        if (trk_ev) begin
          next_state = AISC_TRACK;
        end
      end
      default: next_state = AISC_TRACK;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_q  <= 1'b1;
      trk_q <= 1'b0;
      state <= AISC_TRACK;
    end else begin
      cs_q  <= s_cs_b;
      trk_q <= s_trk;
      state <= next_state;
    end
  end

  // The mode in force during hold follows each accepted change, so one change restarts once.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_mode <= AISC_FULL;
    end else if (cs_fall || mode_chg) begin
      cur_mode <= live_mode;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg             <= CFG_RST;
      pos_sel_o       <= SEL_RST;
      neg_sel_o       <= SEL_RST;
      neg_is_ground_o <= 1'b0;
      pseudo_o        <= 1'b0;
      twos_comp_o     <= 1'b0;
      lsb_shift_o     <= LSB_RST;
      addr_invalid_o  <= 1'b0;
    end else if (cs_fall) begin
      cfg             <= '{single: s_type, addr: s_addr, range_wide: s_range};
      pos_sel_o       <= next_pos;
      neg_sel_o       <= next_neg;
      neg_is_ground_o <= s_type;
      pseudo_o        <= (live_mode == AISC_PSEUDO);
      twos_comp_o     <= next_twos;
      lsb_shift_o     <= next_lsb;
      addr_invalid_o  <= (s_addr[2:1] == ADDR_HI_BAD);
    end
  end

  assign cfg_o = cfg;

  // Acquisition time runs from tracking resuming or from a mode-changing address change.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acq_cnt <= ACQ_CNT_DONE;
    end else if (acq_clr) begin
      acq_cnt <= ACQ_CNT_RST;
    end else if (acq_cnt != ACQ_CNT_DONE) begin
      acq_cnt <= acq_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tracking_o     <= 1'b1;
      acq_ready_o    <= 1'b0;
      acq_restart_o  <= 1'b0;
      conv_corrupt_o <= 1'b0;
    end else begin
      tracking_o    <= (next_state == AISC_TRACK);
      acq_ready_o   <= (next_state == AISC_TRACK) && !acq_clr && (acq_cnt == ACQ_CNT_DONE);
      acq_restart_o <= mode_chg;
      // A type change in the same cycle as a new frame still marks the old one lost.
      if (type_chg) begin
        conv_corrupt_o <= 1'b1;
      end else if (cs_fall) begin
        conv_corrupt_o <= 1'b0;
      end
    end
  end

  // The converter delivers straight binary where code n spans n to n+1 steps; twos
  // complement is the same ladder with the top bit flipped, so the steps stay whole.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_o       <= CODE_RST;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= raw_valid_i;
      if (raw_valid_i) begin
        result_o <= twos_comp_o ? (raw_code_i ^ CODE_MSB) : raw_code_i;
      end
    end
  end
endmodule : aisc_top
`default_nettype wire

// file: include/aisc_pkg.sv
// Shared constants and types for the converter input-select and coding control.
package aisc_pkg;
  localparam int unsigned    CODE_W         = 12;
  localparam int unsigned    REF_CLK_MHZ    = 100;
  localparam int unsigned    ACQ_TIME_NS    = 90;
  localparam int unsigned    ACQ_CYC        = (ACQ_TIME_NS * REF_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]     TRACK_EDGE     = 4'hD;
  localparam logic [3:0]     EDGE_CNT_RST   = 4'h0;
  localparam logic [7:0]     ACQ_CNT_RST    = 8'h00;
  localparam logic [7:0]     ACQ_CNT_DONE   = 8'(ACQ_CYC);
  localparam logic [2:0]     SEL_RST        = 3'h0;
  localparam logic [1:0]     LSB_RST        = 2'h0;
  localparam logic [CODE_W-1:0] CODE_RST    = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MSB    = 12'h800;
  localparam logic [1:0]     ADDR_HI_BAD    = 2'h3;

  typedef enum logic [1:0] {
    AISC_SGL    = 2'h0,
    AISC_FULL   = 2'h1,
    AISC_PSEUDO = 2'h2
  } aisc_mode_t;

  typedef enum logic [1:0] {
    AISC_TRACK = 2'h0,
    AISC_HOLD  = 2'h1
  } aisc_state_t;

  typedef struct packed {
    logic       single;
    logic [2:0] addr;
    logic       range_wide;
  } aisc_cfg_t;

  localparam aisc_cfg_t CFG_RST = '{single: 1'b0, addr: 3'h0, range_wide: 1'b0};
endpackage : aisc_pkg

// file: hdl/aisc_sync.sv
// Two-flop level synchroniser, one bit per lane.
`timescale 1ns/10ps
`default_nettype none
module aisc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : aisc_sync
`default_nettype wire

// file: sim/aisc_host.sv
// Host model: chip-select frames with a counted serial clock.
`timescale 1ns/10ps
`default_nettype none
module aisc_host (
  input  wire logic       go_i,
  input  wire logic [4:0] n_i,
  output var  logic       sclk_o,
  output var  logic       cs_b_o
);
  // The serial clock stands low outside frames; its edges keep a fixed phase, 3 ns before a system clock rise.
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    forever begin
      @(posedge go_i);
      cs_b_o = 1'b0;
      #37;
      repeat (n_i) begin
        #80 sclk_o = 1'b1;
        #80 sclk_o = 1'b0;
      end
      #80 cs_b_o = 1'b1;
    end
  end
endmodule : aisc_host
`default_nettype wire

// file: sim/aisc_checker.sv
// Checker: concurrent assertions on the converter control ports.
`timescale 1ns/10ps
`default_nettype none
module aisc_checker
  import aisc_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_b_i,
  input wire logic              cs_b_i,
  input wire logic [CODE_W-1:0] raw_code_i,
  input wire logic              raw_valid_i,
  input wire aisc_cfg_t         cfg_o,
  input wire logic [2:0]        pos_sel_o,
  input wire logic [2:0]        neg_sel_o,
  input wire logic              neg_is_ground_o,
  input wire logic              pseudo_o,
  input wire logic              twos_comp_o,
  input wire logic [1:0]        lsb_shift_o,
  input wire logic              tracking_o,
  input wire logic              acq_ready_o,
  input wire logic [CODE_W-1:0] result_o,
  input wire logic              result_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Decode relations are only promised once a conversion has latched its pins.
  wire hold = !tracking_o;
  track_drop_a: assert property ($fell(cs_b_i) |-> ##[1:5] !tracking_o) else $error("tracking kept");
  twos_coding_a: assert property (hold |-> twos_comp_o == (cfg_o.range_wide | !(cfg_o.single | cfg_o.addr[0])))
    else $error("coding wrong");
  step_size_a: assert property (hold |-> lsb_shift_o == 2'(cfg_o.range_wide) + 2'(!cfg_o.single))
    else $error("step wrong");
  ground_ref_a: assert property (hold |-> neg_is_ground_o == cfg_o.single) else $error("ground wrong");
  pos_input_a: assert property (hold && cfg_o.addr < 3'h6 |->
    pos_sel_o == (cfg_o.single ? cfg_o.addr : {cfg_o.addr[2:1], 1'b0})) else $error("pos wrong");
  neg_pair_a: assert property (hold && !cfg_o.single |->
    neg_sel_o == {cfg_o.addr[2:1], 1'b1} && pseudo_o == cfg_o.addr[0]) else $error("pair wrong");
  result_code_a: assert property (raw_valid_i |=> result_valid_o &&
    result_o == ($past(raw_code_i) ^ (twos_comp_o ? CODE_MSB : CODE_RST))) else $error("result wrong");
  acq_wait_a: assert property ($rose(tracking_o) |-> !acq_ready_o [*8] ##[1:4] acq_ready_o)
    else $error("acq time wrong");
endmodule : aisc_checker
bind aisc_top aisc_checker chk_u (.ref_clk_i, .rst_b_i, .cs_b_i, .raw_code_i, .raw_valid_i, .cfg_o, .pos_sel_o,
  .neg_sel_o, .neg_is_ground_o, .pseudo_o, .twos_comp_o, .lsb_shift_o, .tracking_o, .acq_ready_o, .result_o,
  .result_valid_o);
`default_nettype wire

// file: sim/aisc_top_tb_top.sv
// Testbench: decode, coding, restart, corruption and hold scenarios.
`timescale 1ns/10ps
`default_nettype none
module aisc_top_tb_top
  import aisc_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, typ = 1'b0, rng = 1'b0, rv = 1'b0, go = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [4:0] n = 5'h0D;
  logic [11:0] raw = 12'h000;
  wire sclk, cs_b;
  aisc_cfg_t cfg;
  logic [2:0] pos;
  logic [1:0] lsb;
  logic [11:0] res;
  logic gnd, twos, trk, rdy, rst_pulse, bad, corrupt;
  int miscompares = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  aisc_host host_u (.go_i(go), .n_i(n), .sclk_o(sclk), .cs_b_o(cs_b));
  aisc_top dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .sclk_i(sclk), .cs_b_i(cs_b), .input_type_select_i(typ),
    .chan_addr_bit0_i(addr[0]), .chan_addr_bit1_i(addr[1]), .chan_addr_bit2_i(addr[2]), .range_i(rng),
    .raw_code_i(raw), .raw_valid_i(rv), .cfg_o(cfg), .pos_sel_o(pos), .neg_sel_o(), .neg_is_ground_o(gnd),
    .pseudo_o(), .twos_comp_o(twos), .lsb_shift_o(lsb), .tracking_o(trk), .acq_ready_o(rdy),
    .acq_restart_o(rst_pulse), .conv_corrupt_o(corrupt), .addr_invalid_o(bad), .result_o(res),
    .result_valid_o());
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Pins settle for several cycles before the fall so the synchronised sampling sees stable levels.
  task automatic start(input logic [4:0] edges);
    n <= edges;
    repeat (4) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : start
  task automatic finish_frame(input logic exp_rdy);
    for (int i = 0; i < 600 && !(cs_b === 1'b1 && rdy === 1'b1); i++) @(posedge clk);
    chk(12'(rdy), 12'(exp_rdy));
    repeat (4) @(posedge clk);
  endtask : finish_frame
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    logic e;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int s = 0; s < 2; s++) for (int a = 0; a < 6; a++) for (int r = 0; r < 2; r++) begin
      typ <= s[0];
      addr <= a[2:0];
      rng <= r[0];
      start(5'h0D);
      e = r[0] | (s == 0 && a[0] == 1'b0);
      chk(12'(twos), 12'(e));
      chk(12'(lsb), 12'(r + 1 - s));
      raw <= 12'hA5C;
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      #1;
      chk(res, 12'hA5C ^ (e ? 12'h800 : 12'h000));
      finish_frame(1'b1);
    end
    $display("decode test done");
    typ <= 1'b0;
    addr <= 3'h0;
    rng <= 1'b0;
    start(5'h0D);
    repeat (50) @(posedge clk);
    addr <= 3'h1;
    rng <= 1'b1;
    for (int i = 0; i < 20 && rst_pulse !== 1'b1; i++) @(negedge clk);
    chk(12'(rst_pulse), 12'h001);
    chk(12'(cfg.range_wide), 12'h000);
    @(negedge clk);
    chk(12'(rst_pulse), 12'h000);
    finish_frame(1'b1);
    $display("restart test done");
    start(5'h0D);
    typ <= 1'b1;
    repeat (8) @(posedge clk);
    chk(12'(corrupt), 12'h001);
    finish_frame(1'b1);
    addr <= 3'h6;
    start(5'h0C);
    chk(12'(bad), 12'h001);
    finish_frame(1'b0);
    chk(12'(trk), 12'h000);
    addr <= 3'h0;
    start(5'h0D);
    finish_frame(1'b1);
    chk(12'(trk), 12'h001);
    $display("hold test done");
    print_verdict();
  end
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule : aisc_top_tb_top
`default_nettype wire
